// ---- rtl/trs_pkg.sv ----
// Package: constants, register map and types for the tone receiver steering block
package trs_pkg;

   // ----------------------------------------------------------------
   // Clock and guard timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ = 40;
   localparam int unsigned PRESENT_GUARD_TIME_US = 40000;
   localparam int unsigned ABSENT_GUARD_TIME_US = 40000;
   localparam int unsigned GUARD_CNT_W = 24;

   // ----------------------------------------------------------------
   // APB register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int unsigned APB_ADDR_W = 12;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_PRES_GUARD = 12'h004;
   localparam logic [11:0] ADDR_ABS_GUARD = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_RX_DIGIT = 12'h010;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_INT_MODE_BIT = 0;
   localparam int unsigned CTRL_CP_MODE_BIT = 1;
   localparam int unsigned STAT_STEER_BIT = 3;
   localparam int unsigned STAT_VALID_BIT = 2;
   localparam int unsigned STAT_EARLY_BIT = 0;
   localparam logic [3:0] RX_CODE_RESET = 4'h0;
   localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

   // Digit code per (low group * 4 + high group), low nibble first
   localparam logic [15:0][3:0] DIGIT_LUT = 64'h0CAB_F987_E654_D321;

   // Detector input bit positions after the synchroniser
   localparam int unsigned SYNC_W = 6;
   localparam int unsigned SYNC_VALID_BIT = 0;
   localparam int unsigned SYNC_CP_BIT = 5;

   // Steering states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PRES = 4'b0010,
      ST_VALID = 4'b0100,
      ST_ABS = 4'b1000
   } trs_state_t;

endpackage : trs_pkg

// ---- rtl/trs_sync.sv ----
// Two-stage synchroniser for asynchronous detector inputs
`timescale 1ns/1ps
module trs_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Asynchronous input and synchronised output
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   // A zero-width synchroniser has nothing to carry
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } trs_sync_t;

   trs_sync_t state_q;
   trs_sync_t state_d;

   // First stage feeds only the second one
   always_comb begin
      state_d.stage1 = asyncIn;
      state_d.stage2 = state_q.stage1;
   end

   // State register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.stage2;

endmodule : trs_sync

// ---- rtl/trs_steering.sv ----
// Tone receiver steering, digit latch, status and call-progress output with APB access
`timescale 1ns/1ps

// Function
// R1: Early tone output follows detector's valid tone pair indication.
// R2: Tone shorter than present guard leaves received digit untouched.
// R3: Tone valid for full present guard latches its decoded code.
// R4: After valid absence, received digit holds until next valid latch.
// R5: Dropout shorter than absent guard is ignored; state and digit unchanged.
// R6: Delayed steer flag stays active for the whole valid signal.
// R7: Data valid flag set on new digit, cleared by status read.
// R8: Interrupt asserts on new digit, released after status read.
// R9: Received digit register holds 4-bit code of last valid pair.
// R10: Present and absent guard periods are independently programmable.
// R11: Call-progress mode stops digit detection; otherwise no call-progress output.
// R12: In call-progress mode, accepted tone drives the shared pin as square wave.
// R13: In call-progress mode, rejected band leaves the shared pin low.
// R14: Recognition time is detect time plus guard time, likewise for gaps.
// R15: Each tone pair maps to a fixed 4-bit code at registration.
// R16: Guard output goes high on registration while early tone stays high.
// R17: In interrupt mode the shared pin pulls low while steer flag active; code holds it low from digit latch until status read.
// R18: Guard periods timed by oscillator-clocked counters with programmable limits.
// R19: Digit register updates only on the rising steer flag transition.
// R20: After reset flags and interrupt inactive, digit register zero.
module trs_steering
   import trs_pkg::*;
#(
   parameter int unsigned GUARD_W = GUARD_CNT_W,
   parameter int unsigned PRES_GUARD_CYC = PRESENT_GUARD_TIME_US * CLK_FREQ_MHZ,
   parameter int unsigned ABS_GUARD_CYC = ABSENT_GUARD_TIME_US * CLK_FREQ_MHZ
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Tone detector, asynchronous
   input wire logic tonePairValid,
   input wire logic [1:0] lowGroupSel,
   input wire logic [1:0] highGroupSel,
   input wire logic cpBandIn,
   // Device pins
   output logic earlyTonePresent,
   output logic guardDriveOut,
   output logic irqOrProgressOut
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (GUARD_W < 2 || GUARD_W > 31) begin : g_bad_width
      $error("GUARD_W must lie between 2 and 31");
   end
   if (PRES_GUARD_CYC >= (1 << GUARD_W) || ABS_GUARD_CYC >= (1 << GUARD_W)) begin : g_bad_guard
      $error("guard cycle count does not fit GUARD_W");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      trs_state_t st;
      logic [GUARD_W-1:0] cnt;
      logic steer;
      logic rxValid;
      logic irqPend;
      logic [3:0] rxCode;
      logic intMode;
      logic cpMode;
      logic [GUARD_W-1:0] presLim;
      logic [GUARD_W-1:0] absLim;
      logic early;
      logic guardOut;
      logic irqPin;
      logic ready;
      logic slvErr;
      logic [31:0] rdata;
   } trs_regs_t;

   localparam trs_regs_t RESET_VAL = '{
      st: ST_IDLE,
      cnt: '0,
      steer: 1'b0,
      rxValid: 1'b0,
      irqPend: 1'b0,
      rxCode: RX_CODE_RESET,
      intMode: 1'b0,
      cpMode: 1'b0,
      presLim: GUARD_W'(PRES_GUARD_CYC),
      absLim: GUARD_W'(ABS_GUARD_CYC),
      early: 1'b0,
      guardOut: 1'b0,
      irqPin: 1'b1,
      ready: 1'b0,
      slvErr: 1'b0,
      rdata: PRDATA_RESET
   };

   trs_regs_t r_q;
   trs_regs_t r_d;

   // ----------------------------------------------------------------
   // Detector input synchronisation
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] syncIn;

   // Code bits may skew by a cycle, harmless since they are sampled after guard time
   trs_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .asyncIn({cpBandIn, highGroupSel, lowGroupSel, tonePairValid}),
      .syncOut(syncIn)
   );

   logic earlyIn;
   logic cpSync;
   logic [3:0] lutIdx;
   logic [3:0] lutCode;

   // Detection is gated off while call-progress mode is selected
   assign earlyIn = syncIn[SYNC_VALID_BIT] && !r_q.cpMode; // [R1] [R11]
   assign cpSync = syncIn[SYNC_CP_BIT];
   assign lutIdx = {syncIn[2:1], syncIn[4:3]};
   assign lutCode = DIGIT_LUT[lutIdx]; // [R15]

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic apbSetup;
   logic apbAccess;
   logic addrHit;
   logic wrCtrl;
   logic statusRead;
   logic guardDone;
   logic latchNow;
   logic [GUARD_W-1:0] curLim;
   logic [31:0] rdMux;

   assign apbSetup = psel && !penable;
   assign apbAccess = psel && penable && r_q.ready;
   assign addrHit = (paddr == ADDR_CTRL) || (paddr == ADDR_PRES_GUARD) || (paddr == ADDR_ABS_GUARD)
                    || (paddr == ADDR_STATUS) || (paddr == ADDR_RX_DIGIT);
   assign wrCtrl = apbAccess && pwrite && (paddr == ADDR_CTRL);
   assign statusRead = apbAccess && !pwrite && (paddr == ADDR_STATUS);

   // Guard counters: limit of N means N tone cycles inside the guard state
   assign curLim = (r_q.st == ST_ABS) ? r_q.absLim : r_q.presLim; // [R10] [R18]
   assign guardDone = ({1'b0, r_q.cnt} + {{GUARD_W{1'b0}}, 1'b1}) >= {1'b0, curLim}; // [R14]
   assign latchNow = (r_q.st == ST_PRES) && earlyIn && guardDone;

   // Read mux, sampled in the setup cycle so prdata comes from a flop
   always_comb begin
      rdMux = '0;
      unique case (paddr)
         ADDR_CTRL: begin
            rdMux[CTRL_INT_MODE_BIT] = r_q.intMode;
            rdMux[CTRL_CP_MODE_BIT] = r_q.cpMode;
         end
         ADDR_PRES_GUARD: rdMux[GUARD_W-1:0] = r_q.presLim;
         ADDR_ABS_GUARD: rdMux[GUARD_W-1:0] = r_q.absLim;
         ADDR_STATUS: begin
            rdMux[STAT_STEER_BIT] = r_q.steer; // [R6]
            rdMux[STAT_VALID_BIT] = r_q.rxValid;
            rdMux[STAT_EARLY_BIT] = r_q.early;
         end
         ADDR_RX_DIGIT: rdMux[3:0] = r_q.rxCode; // [R9]
         default: rdMux = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      r_d = r_q;

      // APB: answer registered in setup, zero wait states
      r_d.ready = apbSetup;
      r_d.slvErr = apbSetup && !addrHit;
      r_d.rdata = apbSetup ? rdMux : '0;
      if (apbAccess && pwrite && !r_q.slvErr) begin
         unique case (paddr)
            ADDR_CTRL: begin
               r_d.intMode = pwdata[CTRL_INT_MODE_BIT];
               r_d.cpMode = pwdata[CTRL_CP_MODE_BIT]; // [R11]
            end
            ADDR_PRES_GUARD: r_d.presLim = pwdata[GUARD_W-1:0]; // [R10]
            ADDR_ABS_GUARD: r_d.absLim = pwdata[GUARD_W-1:0]; // [R10]
            default: r_d.presLim = r_q.presLim;
         endcase
      end

      // Status read clears only what the host actually saw, so a new digit is never lost
      if (statusRead && r_q.rdata[STAT_VALID_BIT]) begin
         r_d.rxValid = 1'b0; // [R7]
         r_d.irqPend = 1'b0; // [R8]
      end

      // Steering state machine
      unique case (r_q.st)
         ST_IDLE: begin
            r_d.cnt = '0;
            if (earlyIn) begin
               r_d.st = ST_PRES;
            end
         end
         ST_PRES: begin
            if (!earlyIn) begin
               r_d.st = ST_IDLE; // [R2]
               r_d.cnt = '0;
            end else if (guardDone) begin
               // Code and flag update together on the rising steer edge
               r_d.st = ST_VALID;
               r_d.cnt = '0;
               r_d.steer = 1'b1; // [R6] [R19]
               r_d.rxCode = lutCode; // [R3] [R15] [R19]
               r_d.rxValid = 1'b1; // [R7]
               r_d.irqPend = r_q.intMode; // [R8] [R17]
            end else begin
               r_d.cnt = r_q.cnt + {{(GUARD_W-1){1'b0}}, 1'b1}; // [R18]
            end
         end
         ST_VALID: begin
            r_d.cnt = '0;
            if (!earlyIn) begin
               r_d.st = ST_ABS;
            end
         end
         ST_ABS: begin
            if (earlyIn) begin
               r_d.st = ST_VALID; // [R5]
               r_d.cnt = '0;
            end else if (guardDone) begin
               r_d.st = ST_IDLE; // [R4]
               r_d.cnt = '0;
               r_d.steer = 1'b0; // [R6]
            end else begin
               r_d.cnt = r_q.cnt + {{(GUARD_W-1){1'b0}}, 1'b1}; // [R18]
            end
         end
         default: begin
            r_d.st = ST_IDLE;
            r_d.cnt = '0;
         end
      endcase

      // Pins, registered straight from next state
      r_d.early = earlyIn; // [R1]
      r_d.guardOut = r_d.steer && earlyIn; // [R16]
      // Call-progress square wave has priority; otherwise low means interrupt
      if (r_d.cpMode) begin
         r_d.irqPin = cpSync; // [R12] [R13]
      end else begin
         r_d.irqPin = !r_d.irqPend; // [R8] [R17]
      end
   end

   // State register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         r_q <= RESET_VAL; // [R20]
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = r_q.rdata;
   assign pready = r_q.ready;
   assign pslverr = r_q.slvErr;
   assign earlyTonePresent = r_q.early;
   assign guardDriveOut = r_q.guardOut;
   assign irqOrProgressOut = r_q.irqPin;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // Short burst returns to idle with the digit untouched
   chk_short_tone_drop: assert property ( // [R2]
      (r_q.st == ST_PRES && !earlyIn) |=> (r_q.st == ST_IDLE) && $stable(r_q.rxCode))
      else $error("short tone changed digit or state");

   // Full guard period latches the looked-up code and raises steer
   chk_latch_code: assert property ( // [R3]
      latchNow |=> r_q.steer && (r_q.rxCode == $past(lutCode)) && r_q.rxValid)
      else $error("valid tone not latched");

   // Digit changes only together with a rising steer flag
   chk_digit_hold: assert property ( // [R19]
      $changed(r_q.rxCode) |-> $rose(r_q.steer))
      else $error("digit changed without steer edge");

   // Short dropout goes back to valid with steer kept
   chk_dropout_ignore: assert property ( // [R5]
      (r_q.st == ST_ABS && earlyIn) |=> (r_q.st == ST_VALID) && r_q.steer && $stable(r_q.rxCode))
      else $error("dropout not ignored");

   // Steer stays up while the tone persists
   chk_steer_hold: assert property ( // [R6]
      (r_q.steer && earlyIn) |=> r_q.steer [*1] ##0 $stable(r_q.rxCode))
      else $error("steer dropped during tone");

   // Status read of a set valid bit clears it unless a new digit arrives
   chk_valid_clear: assert property ( // [R7]
      (statusRead && r_q.rdata[STAT_VALID_BIT] && !latchNow) |=> !r_q.rxValid)
      else $error("data valid not cleared by status read");

   // Interrupt pin pulls low the cycle after a latch in interrupt mode
   chk_irq_assert: assert property ( // [R8]
      (latchNow && r_q.intMode && !r_q.cpMode && !wrCtrl) |=>
         !irqOrProgressOut ##1 (r_q.irqPend || !r_q.intMode || $past(statusRead)))
      else $error("interrupt not raised on new digit");

   // No registration while call-progress mode holds
   chk_cp_no_digit: assert property ( // [R11]
      (r_q.cpMode && $past(r_q.cpMode)) |-> !$rose(r_q.steer) && r_q.st != ST_PRES)
      else $error("digit detected in call-progress mode");

   // Pin follows the synchronised comparator in call-progress mode
   chk_cp_square: assert property ( // [R12]
      (r_q.cpMode && !wrCtrl) |=> irqOrProgressOut == $past(cpSync))
      else $error("call-progress pin does not follow comparator");

   // Rejected band keeps the pin low
   chk_cp_reject_low: assert property ( // [R13]
      (r_q.cpMode && !wrCtrl && !cpSync) |=> !irqOrProgressOut)
      else $error("call-progress pin high without accepted tone");

   // Guard output only with steer and early tone both high
   chk_guard_drive: assert property ( // [R16]
      guardDriveOut |-> r_q.steer && earlyTonePresent)
      else $error("guard output without steer and tone");

   // Every setup cycle is answered in the following cycle
   chk_apb_ready: assert property (
      apbSetup |=> pready ##1 !pready || (psel && !penable))
      else $error("APB answer missing");

   cov_digit_latched: cover property (latchNow ##1 r_q.steer);
   cov_dropout: cover property ((r_q.st == ST_ABS) ##1 (r_q.st == ST_VALID));
   cov_status_clear: cover property (statusRead && r_q.rdata[STAT_VALID_BIT]);
   cov_cp_wave: cover property (r_q.cpMode && $rose(irqOrProgressOut));

endmodule : trs_steering

// ---- verif/trs_apb_host.sv ----
// APB host model standing in for the microcontroller that reads the receiver
`timescale 1ns/1ps
module trs_apb_host
   import trs_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [APB_ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Transfers where pready never came
   int unsigned busTimeouts = 0;

   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // ----------------------------------------------------------------
   // One transfer: setup cycle, then access held until pready
   // ----------------------------------------------------------------
   // Answer is sampled at the rising edge where pready is high, then the request is released
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) busTimeouts++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : trs_apb_host

// ---- verif/trs_steering_tb.sv ----
// Self-checking testbench for the tone receiver steering block
`timescale 1ns/1ps
module trs_steering_tb
   import trs_pkg::*;
;
   logic clk_sys;
   logic reset;
   logic psel, penable, pwrite, pready, pslverr;
   logic [APB_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic tonePairValid, cpBandIn;
   logic [1:0] lowGroupSel, highGroupSel;
   logic earlyTonePresent, guardDriveOut, irqOrProgressOut;
   int unsigned failures = 0;
   int unsigned n_compared = 0;
   logic [31:0] rdv;
   logic rde;
   // Expected code per low*4+high, written out independently of the design
   logic [3:0] codes [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
                              4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};

   // Short guards keep the run brief; expectations follow from 8 and 6
   trs_steering #(.PRES_GUARD_CYC(8), .ABS_GUARD_CYC(6)) i_dut (
      .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tonePairValid(tonePairValid),
      .lowGroupSel(lowGroupSel), .highGroupSel(highGroupSel), .cpBandIn(cpBandIn),
      .earlyTonePresent(earlyTonePresent), .guardDriveOut(guardDriveOut),
      .irqOrProgressOut(irqOrProgressOut));

   trs_apb_host i_host (
      .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // 40 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Compare, bus and tone tasks
   // ----------------------------------------------------------------
   task automatic chkWord(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chkWord

   task automatic chkBit(input string nm, input logic exp, input logic got);
      chkWord(nm, {31'h0, exp}, {31'h0, got});
   endtask : chkBit

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, rdv, rde);
   endtask : wr

   task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      i_host.xfer(1'b0, a, 32'h0000_0000, rdv, rde);
      chkWord(nm, exp, rdv);
   endtask : rdChk

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle

   task automatic toneSet(input logic [1:0] lo, input logic [1:0] hi);
      @(posedge clk_sys);
      tonePairValid <= 1'b1;
      lowGroupSel <= lo;
      highGroupSel <= hi;
   endtask : toneSet

   // Released group lines do not keep their last value
   task automatic toneClr();
      @(posedge clk_sys);
      tonePairValid <= 1'b0;
      lowGroupSel <= ~lowGroupSel;
      highGroupSel <= ~highGroupSel;
   endtask : toneClr

   task automatic cpSet(input logic v);
      @(posedge clk_sys);
      cpBandIn <= v;
   endtask : cpSet

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   // Watchdog, far beyond the expected run of about 1400 cycles
   initial begin
      idle(20000);
      failures++;
      $display("[ERR] watchdog expected end seen hang");
      results();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      tonePairValid = 1'b0;
      lowGroupSel = 2'h0;
      highGroupSel = 2'h0;
      cpBandIn = 1'b0;
      idle(5);
      reset <= 1'b0;
      @(negedge clk_sys);
      chkBit("irq pin", 1'b1, irqOrProgressOut);
      chkBit("guard", 1'b0, guardDriveOut);
      rdChk("status", ADDR_STATUS, 32'h0000_0000);
      rdChk("digit", ADDR_RX_DIGIT, 32'h0000_0000);
      // Long present guard rejects a 16-cycle burst
      wr(ADDR_CTRL, 32'h0000_0001);
      wr(ADDR_PRES_GUARD, 32'h0000_0014);
      rdChk("pres guard", ADDR_PRES_GUARD, 32'h0000_0014);
      rdChk("abs guard", ADDR_ABS_GUARD, 32'h0000_0006);
      toneSet(2'h0, 2'h1);
      idle(15);
      toneClr();
      idle(30);
      rdChk("status", ADDR_STATUS, 32'h0000_0000);
      rdChk("digit", ADDR_RX_DIGIT, 32'h0000_0000);
      // Same tone held past the short guard registers
      wr(ADDR_PRES_GUARD, 32'h0000_0008);
      toneSet(2'h0, 2'h1);
      idle(25);
      @(negedge clk_sys);
      chkBit("early", 1'b1, earlyTonePresent);
      chkBit("guard", 1'b1, guardDriveOut);
      chkBit("irq pin", 1'b0, irqOrProgressOut);
      rdChk("status", ADDR_STATUS, 32'h0000_000D);
      @(negedge clk_sys);
      chkBit("irq pin", 1'b1, irqOrProgressOut);
      rdChk("status", ADDR_STATUS, 32'h0000_0009);
      rdChk("digit", ADDR_RX_DIGIT, 32'h0000_0002);
      // Dropout of three cycles, under the absent guard
      toneClr();
      idle(2);
      toneSet(2'h0, 2'h1);
      idle(20);
      rdChk("status", ADDR_STATUS, 32'h0000_0009);
      toneClr();
      idle(30);
      @(negedge clk_sys);
      chkBit("early", 1'b0, earlyTonePresent);
      chkBit("guard", 1'b0, guardDriveOut);
      rdChk("status", ADDR_STATUS, 32'h0000_0000);
      rdChk("digit", ADDR_RX_DIGIT, 32'h0000_0002);
      // Every tone pair, ending on code 1
      for (int i = 15; i >= 0; i--) begin
         toneSet(i[3:2], i[1:0]);
         idle(25);
         toneClr();
         idle(30);
         rdChk("digit", ADDR_RX_DIGIT, {28'h0, codes[i]});
         rdChk("status", ADDR_STATUS, 32'h0000_0004);
      end
      // Unmapped address is refused
      i_host.xfer(1'b0, 12'h020, 32'h0000_0000, rdv, rde);
      chkWord("unmapped data", 32'h0000_0000, rdv);
      chkBit("unmapped err", 1'b1, rde);
      // Call-progress mode: pin follows the band comparator, no digits
      wr(ADDR_CTRL, 32'h0000_0002);
      toneSet(2'h3, 2'h3);
      repeat (2) begin
         cpSet(1'b1);
         idle(4);
         @(negedge clk_sys);
         chkBit("cp pin", 1'b1, irqOrProgressOut);
         chkBit("early", 1'b0, earlyTonePresent);
         cpSet(1'b0);
         idle(4);
         @(negedge clk_sys);
         chkBit("cp pin", 1'b0, irqOrProgressOut);
      end
      idle(20);
      toneClr();
      idle(30);
      rdChk("status", ADDR_STATUS, 32'h0000_0000);
      rdChk("digit", ADDR_RX_DIGIT, 32'h0000_0001);
      // Interrupt mode off: digit still registers, pin stays high
      wr(ADDR_CTRL, 32'h0000_0000);
      toneSet(2'h0, 2'h2);
      idle(25);
      @(negedge clk_sys);
      chkBit("irq pin", 1'b1, irqOrProgressOut);
      rdChk("status", ADDR_STATUS, 32'h0000_000D);
      toneClr();
      idle(30);
      rdChk("digit", ADDR_RX_DIGIT, 32'h0000_0003);
      // Mid-run reset clears control and digit, pin back high
      wr(ADDR_CTRL, 32'h0000_0003);
      @(posedge clk_sys);
      reset <= 1'b1;
      idle(2);
      reset <= 1'b0;
      rdChk("ctrl", ADDR_CTRL, 32'h0000_0000);
      rdChk("digit", ADDR_RX_DIGIT, 32'h0000_0000);
      @(negedge clk_sys);
      chkBit("irq pin", 1'b1, irqOrProgressOut);
      chkWord("bus timeouts", 32'h0000_0000, i_host.busTimeouts);
      results();
   end
endmodule : trs_steering_tb
